/* File: verilog/arit_pkg.sv */
// shared constants, types and register map of the analyzer remote io terminal
package arit_pkg;

	// timing
	localparam int CLK_MHZ = 100; // system clock rate
	localparam int DEB_TIME_US = 10000; // contact settle time in microseconds
	localparam int DEB_CYC_DEF = DEB_TIME_US * CLK_MHZ; // settle time in cycles

	// command line buffer
	localparam int LINE_DEPTH_DEF = 64; // characters per line
	localparam int CHAR_W = 8; // serial character width

	// serial control characters
	localparam logic [7:0] CH_CTRL_C = 8'h03; // computer mode or pause listing
	localparam logic [7:0] CH_BS = 8'h08; // erase one character
	localparam logic [7:0] CH_CR = 8'h0d; // end of command line
	localparam logic [7:0] CH_CTRL_P = 8'h10; // resume listing
	localparam logic [7:0] CH_CTRL_T = 8'h14; // terminal mode
	localparam logic [7:0] CH_ESC = 8'h1b; // erase whole line
	localparam logic [7:0] CH_QMARK = 8'h3f; // help command
	localparam logic [7:0] CH_LC_A = 8'h61; // first lower case letter
	localparam logic [7:0] CH_LC_Z = 8'h7a; // last lower case letter
	localparam logic [7:0] CH_CASE = 8'h20; // lower to upper case distance

	// apb register byte addresses
	localparam logic [11:0] A_INST = 12'h000; // instrument state, rw
	localparam logic [11:0] A_CONFIG = 12'h004; // mode flags, rw
	localparam logic [11:0] A_STATUS = 12'h008; // terminal status, ro
	localparam logic [11:0] A_CTRL = 12'h00c; // action bits, wo
	localparam logic [11:0] A_LIST_TX = 12'h010; // listing byte, wo
	localparam logic [11:0] A_LINE_BASE = 12'h100; // line buffer window, ro

	// field positions
	localparam int CTRL_CAL_CLR = 0; // ctrl: end calibration mode
	localparam int CTRL_LINE_ACK = 1; // ctrl: line consumed, clear buffer
	localparam int LIST_END_BIT = 8; // list_tx: listing finished

	// calibration mode, also the remote mode label code
	typedef enum logic [1:0] {ARIT_CAL_NONE, ARIT_CAL_ZERO, ARIT_CAL_SPAN, ARIT_CAL_MID} arit_cal_e;

	// instrument state written by software, fault in bit 0
	typedef struct packed {
		logic diag; // diagnostic mode
		logic span_cal; // span calibration from panel
		logic zero_cal; // zero calibration from panel
		logic high_sel; // upper range selected
		logic auto_rng; // automatic range mode active
		logic measurement_valid_output; // reading valid
		logic fault; // any fault present
	} arit_inst_s;

	// terminal status read back
	typedef struct packed {
		logic [7:0] line_len; // buffered characters
		logic id_given; // help line carried an identifier
		arit_cal_e cal; // calibration mode
		logic paused; // listing suspended
		logic listing; // listing in progress
		logic help_req; // help line received
		logic line_ready; // complete line waiting
		logic term_mode; // terminal mode active
	} arit_stat_s;

endpackage : arit_pkg

/* File: verilog/arit_line_mem.sv */
// command line character buffer with registered read data
`timescale 1ns/1ps
module arit_line_mem #(
	parameter int W = 8, // character width
	parameter int DEPTH = 64, // characters
	localparam int AW = $clog2(DEPTH) // address width
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write address
	input wire logic [W-1:0] wdata, // write character
	input wire logic [AW-1:0] raddr, // read address
	output logic [W-1:0] rdata // read character, one cycle late
);

	// all storage of the buffer
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] cells; // character cells
		logic [W-1:0] rd; // read data register
	} arit_mem_s;

	arit_mem_s q; // current state
	arit_mem_s d; // next state

	// write one cell, register the addressed cell
	always_comb begin
		d = q;
		if (we) begin
			d.cells[waddr] = wdata;
		end
		d.rd = q.cells[raddr];
	end

	// storage registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rd;

endmodule : arit_line_mem

/* File: verilog/arit_top.sv */
// remote io terminal: status outputs, contact inputs, serial command line
`timescale 1ns/1ps
module arit_top import arit_pkg::*; #(
	parameter int DEB_CYCLES = DEB_CYC_DEF, // contact settle cycles
	parameter int LINE_DEPTH = LINE_DEPTH_DEF, // line buffer characters
	localparam int CW = $clog2(DEB_CYCLES + 1), // settle counter width
	localparam int AW = $clog2(LINE_DEPTH), // buffer address width
	localparam int LW = $clog2(LINE_DEPTH + 1) // line length width
) (
	input wire logic clk, // 100 mhz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address or write to the read-only line window
	input wire logic [2:0] contact_in, // zero, span, midpoint contacts
	input wire logic [7:0] rx_data, // received character
	input wire logic rx_valid, // received character strobe
	output logic [7:0] tx_data, // character to send
	output logic tx_valid, // character offered
	input wire logic tx_ready, // sender takes character
	output logic [7:0] status_out, // conducting status pins 1 to 8
	output logic [1:0] mode_label // remote calibration mode label
);

	// elaboration checks
	generate
		if (DEB_CYCLES < 1) begin : g_bad_deb
			$error("settle count must be at least one");
		end
		if (LINE_DEPTH < 2 || LINE_DEPTH > 255 || (1 << AW) != LINE_DEPTH) begin : g_bad_depth
			$error("line depth must be a power of two from 2 to 128");
		end
	endgenerate

	// whole state of the block
	typedef struct packed {
		logic [2:0] sync1; // first synchroniser stage
		logic [2:0] sync2; // second synchroniser stage
		logic [2:0] deb; // debounced contact levels
		logic [2:0][CW-1:0] deb_cnt; // settle counters
		arit_inst_s inst; // instrument state
		logic [1:0] cfg; // mode flags 1 and 2
		arit_cal_e cal; // calibration mode
		logic term; // terminal mode
		logic line_ready; // line complete
		logic help_req; // help line seen
		logic id_given; // help line had identifier
		logic listing; // listing running
		logic paused; // listing suspended
		logic [LW-1:0] len; // buffered characters
		logic [7:0] first_ch; // first buffered character
		logic echo_pend; // echo waiting
		logic [7:0] echo_ch; // echo character
		logic hold_full; // listing byte waiting
		logic [7:0] hold_ch; // listing byte
		logic tx_valid; // character offered
		logic [7:0] tx_data; // offered character
		logic pready; // apb ready
		logic pslverr; // apb error
		logic [31:0] prdata; // apb read data
		logic [7:0] status; // status pins
	} arit_state_s;

	arit_state_s q; // current state
	arit_state_s d; // next state

	// buffer port signals
	logic mem_we; // store character
	logic [AW-1:0] mem_waddr; // store position
	logic [7:0] mem_wdata; // stored character
	logic [AW-1:0] mem_raddr; // apb read position
	logic [7:0] mem_rdata; // apb read character

	// work values of the next state logic
	logic acc; // apb access phase
	logic done; // apb transfer completes this edge
	logic hit; // mapped address
	logic stall; // listing byte cannot be taken yet
	logic [31:0] rd; // read value
	logic [9:0] line_idx; // word index into buffer window
	logic [2:0] rise; // debounced contact rising
	logic [7:0] up; // case folded character
	arit_stat_s stat; // status word

	// line buffer
	arit_line_mem #(
		.W(CHAR_W),
		.DEPTH(LINE_DEPTH)
	) u_line (
		.clk(clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// next state of the whole block
	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_waddr = q.len[AW-1:0];
		up = rx_data;
		line_idx = paddr[11:2] - A_LINE_BASE[11:2];
		mem_raddr = line_idx[AW-1:0];
		acc = psel && penable;
		done = acc && q.pready;
		hit = 1'b1;
		stall = 1'b0;
		rd = '0;
		rise = '0;
		stat = '0;

		// status word seen by software
		stat.line_len = 8'(q.len);
		stat.id_given = q.id_given;
		stat.cal = q.cal;
		stat.paused = q.paused;
		stat.listing = q.listing;
		stat.help_req = q.help_req;
		stat.line_ready = q.line_ready;
		stat.term_mode = q.term;

		// apb decode, one wait state before ready
		if (q.pready) begin
			d.pready = 1'b0;
			d.pslverr = 1'b0;
		end else if (acc) begin
			if (paddr == A_INST) begin
				rd = 32'(q.inst);
			end else if (paddr == A_CONFIG) begin
				rd = 32'(q.cfg);
			end else if (paddr == A_STATUS) begin
				rd = 32'(stat);
			end else if (paddr == A_CTRL) begin
				rd = '0;
			end else if (paddr == A_LIST_TX) begin
				stall = pwrite && q.hold_full; // back-pressure on the listing
			end else if (paddr >= A_LINE_BASE && line_idx < 10'(LINE_DEPTH)
					&& paddr[1:0] == 2'b00 && !pwrite) begin
				rd = 32'(mem_rdata); // read issued in setup cycle
			end else begin
				hit = 1'b0; // unmapped or write to the read-only line window
			end
			if (!stall) begin
				d.pready = 1'b1;
				d.prdata = pwrite ? 32'h0000_0000 : rd;
				d.pslverr = !hit;
			end
		end

		// software writes take effect at completion
		if (done && pwrite && !q.pslverr) begin
			if (paddr == A_INST) begin
				d.inst = pwdata[$bits(arit_inst_s)-1:0];
			end else if (paddr == A_CONFIG) begin
				d.cfg = pwdata[1:0];
			end else if (paddr == A_CTRL) begin
				if (pwdata[CTRL_CAL_CLR]) begin
					d.cal = ARIT_CAL_NONE;
				end
				if (pwdata[CTRL_LINE_ACK]) begin
					d.line_ready = 1'b0;
					d.help_req = 1'b0;
					d.id_given = 1'b0;
					d.len = '0;
				end
			end else if (paddr == A_LIST_TX) begin
				if (pwdata[LIST_END_BIT]) begin
					d.listing = 1'b0;
					d.paused = 1'b0;
				end else begin
					d.hold_full = 1'b1;
					d.hold_ch = pwdata[7:0];
				end
			end
		end

		// contact synchronise and debounce, unused contacts have no pin
		for (int i = 0; i < 3; i++) begin
			d.sync1[i] = contact_in[i];
			d.sync2[i] = q.sync1[i];
			if (q.sync2[i] != q.deb[i]) begin
				if (q.deb_cnt[i] == CW'(DEB_CYCLES - 1)) begin
					d.deb[i] = q.sync2[i]; // level stable long enough
					d.deb_cnt[i] = '0;
				end else begin
					d.deb_cnt[i] = q.deb_cnt[i] + 1'b1;
				end
			end else begin
				d.deb_cnt[i] = '0; // bounce restarts the wait
			end
			rise[i] = d.deb[i] && !q.deb[i];
		end

		// contact edge starts calibration once, wins over software clear
		if (rise[0]) begin
			d.cal = ARIT_CAL_ZERO;
		end else if (rise[1]) begin
			d.cal = ARIT_CAL_SPAN;
		end else if (rise[2]) begin
			d.cal = ARIT_CAL_MID;
		end

		// serial sender: echo first, then listing bytes
		if (q.tx_valid) begin
			if (tx_ready) begin
				d.tx_valid = 1'b0;
			end
		end else if (q.echo_pend) begin
			d.tx_valid = 1'b1;
			d.tx_data = q.echo_ch;
			d.echo_pend = 1'b0;
		end else if (q.hold_full && !q.paused) begin
			d.tx_valid = 1'b1;
			d.tx_data = q.hold_ch;
			d.hold_full = 1'b0;
		end

		// received characters
		if (rx_data >= CH_LC_A && rx_data <= CH_LC_Z) begin
			up = rx_data - CH_CASE;
		end
		if (rx_valid) begin
			if (rx_data == CH_CTRL_T) begin
				if (q.cfg == 2'b00) begin
					d.term = 1'b1;
				end
			end else if (rx_data == CH_CTRL_C) begin
				if (q.listing) begin
					d.paused = 1'b1;
				end else begin
					d.term = 1'b0;
				end
			end else if (rx_data == CH_CTRL_P) begin
				if (q.listing) begin
					d.paused = 1'b0;
				end
			end else if (!q.line_ready) begin
				if (rx_data == CH_CR) begin
					d.line_ready = 1'b1;
					if (q.first_ch == CH_QMARK && q.len != '0) begin
						d.help_req = 1'b1;
						d.listing = 1'b1;
						d.paused = 1'b0;
						d.id_given = q.len > LW'(1);
					end
				end else if (rx_data == CH_BS) begin
					if (q.len != '0) begin
						d.len = q.len - 1'b1;
					end
				end else if (rx_data == CH_ESC) begin
					d.len = '0;
				end else if (q.len != LW'(LINE_DEPTH)) begin
					mem_we = 1'b1;
					d.len = q.len + 1'b1;
					if (q.len == '0) begin
						d.first_ch = up;
					end
				end
				if (q.term && !q.echo_pend) begin
					d.echo_pend = 1'b1; // echo only in terminal mode
					d.echo_ch = rx_data;
				end
			end
		end
		mem_wdata = up;

		// flags set forbid terminal mode
		if (q.cfg != 2'b00) begin
			d.term = 1'b0;
		end

		// status pins, conducting is 1
		d.status[0] = !q.inst.fault;
		d.status[1] = q.inst.measurement_valid_output;
		d.status[2] = q.inst.auto_rng && q.inst.high_sel;
		d.status[3] = q.inst.zero_cal || q.cal == ARIT_CAL_ZERO;
		d.status[4] = q.inst.span_cal || q.cal == ARIT_CAL_SPAN
				|| q.cal == ARIT_CAL_MID;
		d.status[5] = q.inst.diag;
		d.status[6] = q.inst.auto_rng && !q.inst.high_sel;
		d.status[7] = 1'b0;
	end

	// state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from registers
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign tx_data = q.tx_data;
	assign tx_valid = q.tx_valid;
	assign status_out = q.status;
	assign mode_label = q.cal;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_listing_ctlc;
		rx_valid && rx_data == CH_CTRL_C && q.listing;
	endsequence

	sequence s_listing_ctlp;
		rx_valid && rx_data == CH_CTRL_P && q.listing;
	endsequence

	// pins are still cleared one edge after reset release, so the check starts after that
	health_pin_a: assert property ($past(rst_n) |-> status_out[0] == !$past(q.inst.fault))
		else $error("health pin does not follow fault");
	valid_pin_a: assert property ($changed(q.inst.measurement_valid_output) |=> status_out[1] == q.inst.measurement_valid_output)
		else $error("valid pin late");
	range_pins_a: assert property (q.inst.auto_rng |=> status_out[2] != status_out[6])
		else $error("range pins disagree");
	zero_pin_a: assert property (q.cal == ARIT_CAL_ZERO |=> status_out[3])
		else $error("zero cal pin off in zero mode");
	span_pin_a: assert property (q.cal == ARIT_CAL_SPAN |=> status_out[4])
		else $error("span cal pin off in span mode");
	diag_pin_a: assert property (q.inst.diag |=> status_out[5])
		else $error("diagnostic pin off");
	zero_start_a: assert property ($rose(q.deb[0]) |-> mode_label == ARIT_CAL_ZERO)
		else $error("zero contact did not start zero mode");
	span_start_a: assert property ($rose(q.deb[1]) && !$rose(q.deb[0])
			|-> mode_label == ARIT_CAL_SPAN)
		else $error("span contact did not start span mode");
	mid_start_a: assert property ($rose(q.deb[2]) && q.deb[1:0] == $past(q.deb[1:0])
			|-> mode_label == ARIT_CAL_MID)
		else $error("third contact did not start midpoint mode");
	term_enter_a: assert property (rx_valid && rx_data == CH_CTRL_T && q.cfg == 2'b00
			|=> q.term)
		else $error("control t ignored");
	term_block_a: assert property (q.cfg != 2'b00 |=> !q.term)
		else $error("terminal mode with flags set");
	comp_enter_a: assert property (rx_valid && rx_data == CH_CTRL_C && !q.listing
			|=> !q.term)
		else $error("control c did not select computer mode");
	line_end_a: assert property ($rose(q.line_ready) |-> $past(rx_valid && rx_data == CH_CR))
		else $error("line ready without carriage return");
	bs_erase_a: assert property (rx_valid && rx_data == CH_BS && !q.line_ready && q.len != '0
			|=> q.len == $past(q.len) - 1'b1)
		else $error("backspace did not remove one character");
	esc_clear_a: assert property (rx_valid && rx_data == CH_ESC && !q.line_ready
			|=> q.len == '0)
		else $error("escape did not clear line");
	list_pause_a: assert property (s_listing_ctlc |=> q.paused ##1 (q.paused || !q.listing
			|| $past(rx_valid)))
		else $error("control c did not pause listing");
	list_resume_a: assert property (s_listing_ctlp |=> !q.paused)
		else $error("control p did not resume listing");
	pin_eight_a: assert property (status_out[7] == 1'b0)
		else $error("unused pin conducting");
	settle_a: assert property ($rose(q.deb[0]) |-> $past(q.sync2[0], 2))
		else $error("contact accepted before settling");

endmodule : arit_top

/* File: verification/arit_term_model.sv */
// serial terminal model: takes offered characters, can stall, logs what it got
`timescale 1ns/1ps
module arit_term_model (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] tx_data, // character offered by the device
	input wire logic tx_valid, // character offered
	output logic tx_ready, // terminal takes character
	input wire logic stall, // terminal busy, refuses characters
	output logic [7:0] last_char, // last character taken
	output logic [15:0] char_count // characters taken so far
);
	// ready follows the busy request, taken on a rising edge only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
			last_char <= 8'h00;
			char_count <= 16'h0000;
		end else begin
			tx_ready <= !stall;
			// a character counts as taken when valid and ready meet at an edge
			if (tx_valid && tx_ready) begin
				last_char <= tx_data;
				char_count <= char_count + 16'h0001;
			end
		end
	end
endmodule : arit_term_model

/* File: verification/tb_top.sv */
// self-checking bench of the remote io terminal
`timescale 1ns/1ps
module tb_top;
	import arit_pkg::*;
	logic clk = 1'b0; // system clock
	logic rst_n = 1'b0; // reset, active low
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
	logic [11:0] paddr = 12'h000; // apb address
	logic [31:0] pwdata = 32'h0, prdata; // apb data
	logic pready, pslverr; // apb answer
	logic [2:0] contact_in = 3'h0; // contacts
	logic [7:0] rx_data = 8'h00, tx_data; // serial characters
	logic rx_valid = 1'b0, tx_valid, tx_ready; // serial strobes
	logic [7:0] status_out, last_char; // pins, terminal log
	logic [1:0] mode_label; // remote label
	logic [15:0] char_count; // terminal character count
	logic stall = 1'b0; // terminal busy
	int miscompares = 0, num_checks = 0, cycles = 0;
	logic [31:0] rd; // read data
	logic err; // read error
	logic [6:0] vals [10] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0c, 7'h10, 7'h20, 7'h40, 7'h7f, 7'h06};
	always #5 clk = ~clk;
	arit_top #(.DEB_CYCLES(4)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .contact_in(contact_in), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .status_out(status_out),
		.mode_label(mode_label));
	arit_term_model i_term (.clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .stall(stall), .last_char(last_char), .char_count(char_count));
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	// compare and report
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one received character, then a quiet gap
	task automatic send(input logic [7:0] c);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= c;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : send
	// expected pin image from an instrument state word
	function automatic logic [7:0] pins(input logic [6:0] v);
		return {1'b0, v[2] & ~v[3], v[6], v[5], v[4], v[2] & v[3], v[1], ~v[0]};
	endfunction : pins
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// reset values
		apb(1'b0, A_INST, 32'h0);
		check("inst reset", rd, 32'h0);
		apb(1'b0, A_CONFIG, 32'h0);
		check("config reset", rd, 32'h0);
		apb(1'b0, 12'h0f0, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		$display("test reset done");
		// status pins for each of ten instrument states
		foreach (vals[i]) begin
			apb(1'b1, A_INST, {25'h0, vals[i]});
			repeat (2) @(posedge clk);
			check("status pins", {24'h0, status_out}, {24'h0, pins(vals[i])});
		end
		apb(1'b1, A_INST, 32'h0);
		$display("test status done");
		// contacts: each starts its mode once, glitches ignored
		for (int i = 0; i < 3; i++) begin
			contact_in[i] <= 1'b1;
			repeat (14) @(posedge clk);
			check("mode label", {30'h0, mode_label}, i + 1);
			check("cal pin", {31'h0, status_out[i == 0 ? 3 : 4]}, 32'h1);
			apb(1'b1, A_CTRL, 32'h1);
			repeat (14) @(posedge clk);
			check("held no retrigger", {30'h0, mode_label}, 32'h0);
			contact_in[i] <= 1'b0;
			repeat (14) @(posedge clk);
		end
		contact_in[0] <= 1'b1;
		@(posedge clk);
		contact_in[0] <= 1'b0;
		repeat (14) @(posedge clk);
		check("glitch ignored", {30'h0, mode_label}, 32'h0);
		$display("test contacts done");
		// terminal mode, echo, editing
		apb(1'b1, A_CONFIG, 32'h1);
		send(CH_CTRL_T);
		apb(1'b0, A_STATUS, 32'h0);
		check("term blocked", rd[0], 32'h0);
		apb(1'b1, A_CONFIG, 32'h0);
		send(CH_CTRL_T);
		send(8'h61);
		apb(1'b0, A_STATUS, 32'h0);
		check("term mode", rd[0], 32'h1);
		check("echo", {24'h0, last_char}, 32'h61);
		send(8'h62);
		send(CH_BS);
		apb(1'b0, A_STATUS, 32'h0);
		check("length after erase", rd[15:8], 32'h1);
		check("no line before cr", rd[1], 32'h0);
		apb(1'b0, A_LINE_BASE, 32'h0);
		check("stored char", rd, 32'h41);
		send(CH_ESC);
		apb(1'b0, A_STATUS, 32'h0);
		check("line discarded", rd[15:8], 32'h0);
		$display("test editing done");
		// help listing with pause and resume
		send(CH_QMARK);
		send(CH_CR);
		apb(1'b0, A_STATUS, 32'h0);
		check("help listing", rd[3:1], 32'h7);
		check("no id", rd[7], 32'h0);
		apb(1'b1, A_LIST_TX, 32'h48);
		repeat (4) @(posedge clk);
		check("listing byte", {24'h0, last_char}, 32'h48);
		send(CH_CTRL_C);
		apb(1'b0, A_STATUS, 32'h0);
		check("paused", rd[4], 32'h1);
		check("mode kept", rd[0], 32'h1);
		send(CH_CTRL_P);
		apb(1'b0, A_STATUS, 32'h0);
		check("resumed", rd[4], 32'h0);
		apb(1'b1, A_LIST_TX, 32'h100);
		apb(1'b1, A_CTRL, 32'h2);
		apb(1'b0, A_STATUS, 32'h0);
		check("listing over", rd[3:1], 32'h0);
		send(CH_QMARK);
		send(8'h20);
		send(8'h31);
		send(8'h32);
		send(CH_CR);
		apb(1'b0, A_STATUS, 32'h0);
		check("help with id", {rd[7], rd[2]}, 32'h3);
		apb(1'b1, A_LIST_TX, 32'h100);
		apb(1'b1, A_CTRL, 32'h2);
		$display("test help done");
		// stalled terminal keeps the echo offered
		stall <= 1'b1;
		send(8'h71);
		repeat (6) @(posedge clk);
		check("echo held", {23'h0, tx_valid, tx_data}, 32'h171);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		check("echo taken", {24'h0, last_char}, 32'h71);
		send(CH_ESC);
		// computer mode, no echo
		send(CH_CTRL_C);
		apb(1'b0, A_STATUS, 32'h0);
		check("computer mode", rd[0], 32'h0);
		rd = {16'h0, char_count};
		send(8'h78);
		repeat (4) @(posedge clk);
		check("no echo", {16'h0, char_count}, rd);
		$display("test modes done");
		close_out();
	end
endmodule : tb_top
